// [src/lpsmi_ctrl.sv]
// Low-power clock state and management interrupt entry controller.
//
// Overview of operation
// - A stop request enters halt grant with an acknowledge and stops only the core clock.
// - In halt grant the block still acknowledges snoops and accepts interrupts.
// - Removing the stop-clock request restarts every clock and resumes execution.
// - The stop-clock pin is synchronised and never touches the bus clock domain.
// - A sleep request moves to sleep only from either halt-grant variant.
// - In sleep all internal clock enables are off, leaving only the PLL.
// - In sleep snoops and interrupts are ignored.
// - In sleep only reset, sleep request removal, a deep-sleep request and bus clock loss are acted on.
// - Sleep request removal returns to the halt-grant variant it came from, clocks restarted.
// - A deep-sleep request while in sleep moves to deep sleep.
// - A build option can disable the sleep state altogether.
// - The management interrupt pin is synchronised before use.
// - An accepted management interrupt saves state and enters protected handler mode.
// - After entering that mode an acknowledge goes out, then handler fetch starts.
// - A management interrupt present at reset release puts all outputs in high impedance.
// - Reset releases bus outputs within two clocks and invalidates caches without writeback.
`timescale 1ns/1ps
`include "lpsmi_params.svh"

module lpsmi_ctrl #(
   parameter bit SLEEP_EN = 1'b1
) (
   // Bus clock and system reset.
   input wire logic clk,
   input wire logic rstn,
   // Asynchronous request pins from chipset logic.
   input wire logic clock_stop_request_n,
   input wire logic sleep_request_n,
   input wire logic deep_sleep_request_n,
   input wire logic sys_mgmt_irq_n,
   input wire logic bus_clk_gone,
   // Bus-side requests on the bus clock.
   input wire logic snoop_req,
   input wire logic irq_req,
   input wire logic handler_exit,
   // Clock gating and bus acknowledge.
   output lpsmi_pkg::lpsmi_clk_en_t clk_en_q,
   output lpsmi_pkg::lpsmi_ack_t ack_q,
   output logic snoop_ack_q,
   output logic irq_accept_q,
   // Management interrupt entry.
   output logic state_save_q,
   output logic handler_mode_q,
   output logic fetch_start_q,
   // Reset effects and the power state.
   output logic bus_out_en_q,
   output logic outputs_hiz_q,
   output logic cache_inv_q,
   output lpsmi_pkg::lpsmi_pwr_t pwr_q
);

   lpsmi_pkg::lpsmi_pins_t pins;
   logic [`LPSMI_PIN_W-1:0] pins_raw;
   lpsmi_pkg::lpsmi_pwr_t pwr_d;
   lpsmi_pkg::lpsmi_smi_t smi_q;
   lpsmi_pkg::lpsmi_smi_t smi_d;
   logic halt_ext_q;
   logic smi_prev_q;
   logic smi_pend_q;
   logic rst_seen_q;
   logic smi_take;
   logic halt_entry;

   // True while the core can still see snoops and interrupts.
   function automatic logic awake(lpsmi_pkg::lpsmi_pwr_t s);
      awake = (s == lpsmi_pkg::PWR_RUN) || (s == lpsmi_pkg::PWR_HALT) ||
              (s == lpsmi_pkg::PWR_HALT_EXT);
   endfunction

   // Clock enable pattern for each power state.
   function automatic lpsmi_pkg::lpsmi_clk_en_t clk_pattern(lpsmi_pkg::lpsmi_pwr_t s);
      unique case (s)
         lpsmi_pkg::PWR_RUN: clk_pattern = `LPSMI_CLKEN_ALL;
         lpsmi_pkg::PWR_HALT, lpsmi_pkg::PWR_HALT_EXT: clk_pattern = `LPSMI_CLKEN_HALT;
         default: clk_pattern = `LPSMI_CLKEN_OFF;
      endcase
   endfunction

   // All asynchronous pins pass the same two-stage synchroniser.
   lpsmi_sync #(
      .W(`LPSMI_PIN_W)
   ) u_sync (
      .clk(clk),
      .async_in({clock_stop_request_n, sleep_request_n, deep_sleep_request_n,
                 sys_mgmt_irq_n, bus_clk_gone}),
      .sync_out(pins_raw)
   );
   assign pins = lpsmi_pkg::lpsmi_pins_t'(pins_raw);

   // Power state next value; the entry sequence must finish before halting.
   always_comb begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         lpsmi_pkg::PWR_RUN: begin
            if (!pins.stop_n && (smi_q == lpsmi_pkg::SMI_IDLE ||
                smi_q == lpsmi_pkg::SMI_ACTIVE)) begin
               // A halt taken inside a running handler is the extended variant.
               pwr_d = (smi_q == lpsmi_pkg::SMI_ACTIVE) ? lpsmi_pkg::PWR_HALT_EXT :
                       lpsmi_pkg::PWR_HALT;
            end
         end
         lpsmi_pkg::PWR_HALT, lpsmi_pkg::PWR_HALT_EXT: begin
            if (SLEEP_EN && !pins.sleep_n) begin
               pwr_d = lpsmi_pkg::PWR_SLEEP;
            end else if (pins.stop_n) begin
               pwr_d = lpsmi_pkg::PWR_RUN;
            end
         end
         lpsmi_pkg::PWR_SLEEP: begin
            if (!pins.deep_n || pins.bclk_gone) begin
               pwr_d = lpsmi_pkg::PWR_DEEP;
            end else if (pins.sleep_n) begin
               pwr_d = halt_ext_q ? lpsmi_pkg::PWR_HALT_EXT : lpsmi_pkg::PWR_HALT;
            end
         end
         lpsmi_pkg::PWR_DEEP: begin
            if (pins.deep_n && !pins.bclk_gone) begin
               pwr_d = lpsmi_pkg::PWR_SLEEP;
            end
         end
         default: pwr_d = lpsmi_pkg::PWR_RUN;
      endcase
   end

   // Power state and its clock enables, updated together so they never disagree.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pwr_q <= lpsmi_pkg::PWR_RUN;
         clk_en_q <= `LPSMI_CLKEN_ALL;
      end else begin
         pwr_q <= pwr_d;
         clk_en_q <= clk_pattern(pwr_d);
      end
   end

   // The halt variant entered is remembered, so the sleep exit can return to
   // the variant it left rather than guess from the handler state later.
   assign halt_entry = (pwr_q == lpsmi_pkg::PWR_RUN) && (pwr_d != lpsmi_pkg::PWR_RUN);
   always_ff @(posedge clk) begin
      if (!rstn) begin
         halt_ext_q <= 1'b0;
      end else if (halt_entry) begin
         halt_ext_q <= (pwr_d == lpsmi_pkg::PWR_HALT_EXT);
      end
   end

   // Acknowledge transactions: one cycle each, halt grant on entry.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ack_q <= '0;
      end else if (halt_entry) begin
         ack_q <= '{valid: 1'b1, kind: lpsmi_pkg::ACK_HALT_GRANT};
      end else if (smi_d == lpsmi_pkg::SMI_ACK) begin
         ack_q <= '{valid: 1'b1, kind: lpsmi_pkg::ACK_MGMT_IRQ};
      end else begin
         ack_q <= '0;
      end
   end

   // Snoops and interrupts are served while awake and dropped in sleep.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         snoop_ack_q <= 1'b0;
         irq_accept_q <= 1'b0;
      end else begin
         snoop_ack_q <= snoop_req && awake(pwr_q);
         irq_accept_q <= irq_req && awake(pwr_q);
      end
   end

   // A falling edge of the synchronised pin makes the interrupt pending.
   // A new edge in the cycle it is taken wins, so none is lost.
   assign smi_take = smi_pend_q && smi_q == lpsmi_pkg::SMI_IDLE &&
                     pwr_q == lpsmi_pkg::PWR_RUN && pins.stop_n;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         smi_prev_q <= 1'b1;
         smi_pend_q <= 1'b0;
      end else begin
         smi_prev_q <= pins.smi_n;
         if (smi_prev_q && !pins.smi_n) begin
            smi_pend_q <= 1'b1;
         end else if (smi_take) begin
            smi_pend_q <= 1'b0;
         end
      end
   end

   // Entry sequence: save, acknowledge, fetch, then run the handler.
   always_comb begin
      smi_d = smi_q;
      unique case (smi_q)
         lpsmi_pkg::SMI_IDLE: if (smi_take) smi_d = lpsmi_pkg::SMI_SAVE;
         lpsmi_pkg::SMI_SAVE: smi_d = lpsmi_pkg::SMI_ACK;
         lpsmi_pkg::SMI_ACK: smi_d = lpsmi_pkg::SMI_FETCH;
         lpsmi_pkg::SMI_FETCH: smi_d = lpsmi_pkg::SMI_ACTIVE;
         lpsmi_pkg::SMI_ACTIVE: begin
            if (handler_exit && pwr_q == lpsmi_pkg::PWR_RUN) begin
               smi_d = lpsmi_pkg::SMI_IDLE;
            end
         end
         default: smi_d = lpsmi_pkg::SMI_IDLE;
      endcase
   end

   // Entry sequence state and its strobes.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         smi_q <= lpsmi_pkg::SMI_IDLE;
         state_save_q <= 1'b0;
         handler_mode_q <= 1'b0;
         fetch_start_q <= 1'b0;
      end else begin
         smi_q <= smi_d;
         state_save_q <= (smi_d == lpsmi_pkg::SMI_SAVE);
         handler_mode_q <= (smi_d != lpsmi_pkg::SMI_IDLE);
         fetch_start_q <= (smi_d == lpsmi_pkg::SMI_FETCH);
      end
   end

   // Reset: bus outputs drop at the first edge, well inside the release
   // limit, and caches are invalidated without writeback.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rst_seen_q <= 1'b0;
         bus_out_en_q <= 1'b0;
         outputs_hiz_q <= 1'b0;
         cache_inv_q <= 1'b1;
      end else begin
         rst_seen_q <= 1'b1;
         cache_inv_q <= 1'b0;
         if (!rst_seen_q) begin
            outputs_hiz_q <= !pins.smi_n;
            bus_out_en_q <= pins.smi_n;
         end
      end
   end

   // Helper count of cycles since reset was first seen.
   logic [1:0] rst_cnt_q;
   always_ff @(posedge clk) begin
      if (rstn) begin
         rst_cnt_q <= 2'h0;
      end else if (rst_cnt_q != 2'h3) begin
         rst_cnt_q <= rst_cnt_q + 2'h1;
      end
   end

   // Halt grant keeps only bus and interrupt controller clocks.
   a_halt_clk_gating: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q == lpsmi_pkg::PWR_HALT || pwr_q == lpsmi_pkg::PWR_HALT_EXT) |->
      clk_en_q == `LPSMI_CLKEN_HALT)
      else $error("halt grant clock enables wrong");

   a_halt_ack_sent: assert property (@(posedge clk) disable iff (!rstn)
      ($past(pwr_q) == lpsmi_pkg::PWR_RUN && pwr_q != lpsmi_pkg::PWR_RUN) |->
      ack_q.valid && ack_q.kind == lpsmi_pkg::ACK_HALT_GRANT)
      else $error("no halt grant acknowledge on entry");

   a_halt_serves_irq: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q inside {lpsmi_pkg::PWR_HALT, lpsmi_pkg::PWR_HALT_EXT} && irq_req) |=>
      irq_accept_q)
      else $error("interrupt not served in halt grant");

   a_halt_exit_run: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q inside {lpsmi_pkg::PWR_HALT, lpsmi_pkg::PWR_HALT_EXT} &&
      pins.stop_n && pins.sleep_n) |=>
      pwr_q == lpsmi_pkg::PWR_RUN && clk_en_q == `LPSMI_CLKEN_ALL)
      else $error("halt exit did not restart clocks");

   a_stop_sync_delay: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q == lpsmi_pkg::PWR_RUN && $fell(clock_stop_request_n) && pins.stop_n) |=>
      pwr_q == lpsmi_pkg::PWR_RUN && clk_en_q.bus)
      else $error("stop request acted on before synchronisation");

   a_sleep_from_halt: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q == lpsmi_pkg::PWR_RUN) |=> pwr_q != lpsmi_pkg::PWR_SLEEP)
      else $error("sleep entered from run");

   a_sleep_clk_off: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q == lpsmi_pkg::PWR_SLEEP || pwr_q == lpsmi_pkg::PWR_DEEP) |->
      clk_en_q == `LPSMI_CLKEN_OFF)
      else $error("clock enabled in sleep");

   a_sleep_deaf: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q == lpsmi_pkg::PWR_SLEEP) |=> !snoop_ack_q && !irq_accept_q)
      else $error("snoop or interrupt served in sleep");

   a_sleep_hold: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q == lpsmi_pkg::PWR_SLEEP && !pins.sleep_n && pins.deep_n && !pins.bclk_gone)
      |=> pwr_q == lpsmi_pkg::PWR_SLEEP)
      else $error("sleep left without a wake event");

   a_sleep_return: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q == lpsmi_pkg::PWR_SLEEP && pins.sleep_n && pins.deep_n && !pins.bclk_gone)
      |=> (pwr_q == (halt_ext_q ? lpsmi_pkg::PWR_HALT_EXT : lpsmi_pkg::PWR_HALT)))
      else $error("sleep exit to wrong halt variant");

   a_deep_entry: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q == lpsmi_pkg::PWR_SLEEP && !pins.deep_n) |=> pwr_q == lpsmi_pkg::PWR_DEEP)
      else $error("deep sleep not entered");

   a_sleep_disabled: assert property (@(posedge clk) disable iff (!rstn)
      !SLEEP_EN |-> pwr_q != lpsmi_pkg::PWR_SLEEP)
      else $error("sleep entered while disabled");

   a_smi_entry_seq: assert property (@(posedge clk) disable iff (!rstn)
      (smi_q == lpsmi_pkg::SMI_SAVE) |-> state_save_q && handler_mode_q ##1
      ack_q.valid && ack_q.kind == lpsmi_pkg::ACK_MGMT_IRQ ##1 fetch_start_q)
      else $error("management interrupt entry out of order");

   a_smi_accept_time: assert property (@(posedge clk) disable iff (!rstn)
      smi_take |=> smi_q == lpsmi_pkg::SMI_SAVE ##3 smi_q == lpsmi_pkg::SMI_ACTIVE)
      else $error("handler fetch not reached in three cycles");

   a_hiz_capture: assert property (@(posedge clk) disable iff (!rstn)
      (!rst_seen_q && !pins.smi_n) |=> outputs_hiz_q && !bus_out_en_q)
      else $error("outputs not high impedance after reset strap");

   a_reset_release: assert property (@(posedge clk)
      (rst_cnt_q >= 2'(`LPSMI_BUS_RELEASE_CLKS) && !rstn) |-> !bus_out_en_q && cache_inv_q)
      else $error("bus outputs not released in reset");

   a_deep_to_sleep: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_q == lpsmi_pkg::PWR_DEEP) |=> pwr_q inside {lpsmi_pkg::PWR_DEEP,
      lpsmi_pkg::PWR_SLEEP})
      else $error("deep sleep exit skipped sleep");

endmodule

// [common/lpsmi_params.svh]
// Constants of the low-power state and management interrupt controller.
`ifndef LPSMI_PARAMS_SVH
`define LPSMI_PARAMS_SVH

// Clock enable patterns, ordered {core, bus, interrupt controller}.
`define LPSMI_CLKEN_ALL 3'h7
`define LPSMI_CLKEN_HALT 3'h3
`define LPSMI_CLKEN_OFF 3'h0

// Number of flip-flops in each pin synchroniser.
`define LPSMI_SYNC_STAGES 2

// Bus clocks allowed between reset seen and all bus outputs released.
`define LPSMI_BUS_RELEASE_CLKS 2

// Width of the synchronised pin group.
`define LPSMI_PIN_W 5

`endif

// [common/lpsmi_pkg.sv]
// Types shared by the low-power state and management interrupt controller.
package lpsmi_pkg;

   // Clock power states seen from the core.
   typedef enum logic [2:0] {
      PWR_RUN,
      PWR_HALT,
      PWR_HALT_EXT,
      PWR_SLEEP,
      PWR_DEEP
   } lpsmi_pwr_t;

   // Management interrupt entry sequence.
   typedef enum logic [2:0] {
      SMI_IDLE,
      SMI_SAVE,
      SMI_ACK,
      SMI_FETCH,
      SMI_ACTIVE
   } lpsmi_smi_t;

   // Kind of acknowledge transaction placed on the processor bus.
   typedef enum logic {
      ACK_HALT_GRANT,
      ACK_MGMT_IRQ
   } lpsmi_ack_kind_t;

   typedef struct packed {
      logic valid;
      lpsmi_ack_kind_t kind;
   } lpsmi_ack_t;

   typedef struct packed {
      logic core;
      logic bus;
      logic icu;
   } lpsmi_clk_en_t;

   // Synchronised pin group, all active low except the clock loss flag.
   typedef struct packed {
      logic stop_n;
      logic sleep_n;
      logic deep_n;
      logic smi_n;
      logic bclk_gone;
   } lpsmi_pins_t;

endpackage

// [src/lpsmi_sync.sv]
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
`include "lpsmi_params.svh"

module lpsmi_sync #(
   parameter int W = `LPSMI_PIN_W
) (
   // Clock.
   input wire logic clk,
   // Asynchronous pins and their synchronised copy.
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // No reset on purpose: the pins must be tracked during reset so a strap
   // level is valid at the edge where reset is released.
   always_ff @(posedge clk) begin
      meta_q <= async_in;
      sync_out <= meta_q;
   end

endmodule

// [bench/lpsmi_chipset.sv]
// Behavioural chipset model that drives the power-state and management interrupt pins.
`timescale 1ns/1ps

module lpsmi_chipset (
   // Bus clock.
   input wire logic clk,
   // Request pins, all idle high except the clock loss flag.
   output lpsmi_pkg::lpsmi_pins_t pins
);

   // Pins start idle so the core leaves reset in the run state.
   initial begin
      pins = 5'h1e;
   end

   // Pins change on the falling clock edge, half a cycle away from the core's rising sampling edge.
   task automatic drive(input lpsmi_pkg::lpsmi_pins_t p);
      @(negedge clk);
      pins = p;
   endtask

endmodule

// [bench/lpsmi_ctrl_tb.sv]
// Self-checking bench for the low-power state and management interrupt controller.
`timescale 1ns/1ps
`include "lpsmi_params.svh"

module lpsmi_ctrl_tb;
   // Pin patterns ordered {stop_n, sleep_n, deep_n, mgmt_n, clock_gone}.
   localparam logic [4:0] P_IDLE = 5'h1e;
   localparam logic [4:0] P_STOP = 5'h0e;
   localparam logic [4:0] P_SLEEP = 5'h06;
   localparam logic [4:0] P_DEEP = 5'h02;
   localparam logic [4:0] P_GONE = 5'h07;
   localparam logic [4:0] P_SLP_RUN = 5'h16;
   localparam logic [4:0] P_MGMT = 5'h1c;
   localparam int MAX_CYCLES = 2000;

   logic clk;
   logic rstn;
   logic snoop_req;
   logic irq_req;
   logic handler_exit;
   lpsmi_pkg::lpsmi_pins_t pins;
   lpsmi_pkg::lpsmi_clk_en_t clk_en_q;
   lpsmi_pkg::lpsmi_ack_t ack_q;
   logic snoop_ack_q, irq_accept_q, state_save_q, handler_mode_q, fetch_start_q;
   logic bus_out_en_q, outputs_hiz_q, cache_inv_q;
   lpsmi_pkg::lpsmi_pwr_t pwr_q;
   lpsmi_pkg::lpsmi_pwr_t pwr_off;
   int n_mismatch = 0;
   int n_checks = 0;
   int n_cycles = 0;

   lpsmi_chipset lpsmi_chipset_i (.clk(clk), .pins(pins));

   lpsmi_ctrl #(.SLEEP_EN(1'b1)) lpsmi_ctrl_i (
      .clk(clk), .rstn(rstn), .clock_stop_request_n(pins.stop_n),
      .sleep_request_n(pins.sleep_n), .deep_sleep_request_n(pins.deep_n),
      .sys_mgmt_irq_n(pins.smi_n), .bus_clk_gone(pins.bclk_gone), .snoop_req(snoop_req),
      .irq_req(irq_req), .handler_exit(handler_exit), .clk_en_q(clk_en_q), .ack_q(ack_q),
      .snoop_ack_q(snoop_ack_q), .irq_accept_q(irq_accept_q), .state_save_q(state_save_q),
      .handler_mode_q(handler_mode_q), .fetch_start_q(fetch_start_q),
      .bus_out_en_q(bus_out_en_q), .outputs_hiz_q(outputs_hiz_q),
      .cache_inv_q(cache_inv_q), .pwr_q(pwr_q));

   // A twin built without the sleep state shares every input with the main instance.
   lpsmi_ctrl #(.SLEEP_EN(1'b0)) lpsmi_ctrl_nosleep_i (
      .clk(clk), .rstn(rstn), .clock_stop_request_n(pins.stop_n),
      .sleep_request_n(pins.sleep_n), .deep_sleep_request_n(pins.deep_n),
      .sys_mgmt_irq_n(pins.smi_n), .bus_clk_gone(pins.bclk_gone), .snoop_req(snoop_req),
      .irq_req(irq_req), .handler_exit(handler_exit), .clk_en_q(), .ack_q(),
      .snoop_ack_q(), .irq_accept_q(), .state_save_q(), .handler_mode_q(),
      .fetch_start_q(), .bus_out_en_q(), .outputs_hiz_q(), .cache_inv_q(), .pwr_q(pwr_off));

   // Free-running bus clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // A hang is cut short after well over the expected run length.
   always @(posedge clk) begin
      n_cycles++;
      if (n_cycles == MAX_CYCLES) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk_vec(input string what, input logic [2:0] exp, input logic [2:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Raises one bus request for a cycle and reports whether any answer pulse followed.
   task automatic probe(input bit irq, output logic seen);
      seen = 1'b0;
      snoop_req = !irq;
      irq_req = irq;
      @(negedge clk);
      snoop_req = 1'b0;
      irq_req = 1'b0;
      repeat (3) begin
         seen = seen | (irq ? irq_accept_q : snoop_ack_q);
         @(negedge clk);
      end
   endtask

   task automatic t_halt();
      logic seen;
      lpsmi_chipset_i.drive(P_STOP);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_HALT, pwr_q);
      chk_vec("clock enables", `LPSMI_CLKEN_HALT, clk_en_q);
      chk_vec("acknowledge", 3'h2, {1'b0, ack_q});
      probe(1'b0, seen);
      chk_bit("snoop answer", 1'b1, seen);
      probe(1'b1, seen);
      chk_bit("interrupt answer", 1'b1, seen);
      lpsmi_chipset_i.drive(P_IDLE);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_RUN, pwr_q);
      chk_vec("clock enables", `LPSMI_CLKEN_ALL, clk_en_q);
      $display("test halt grant done");
   endtask

   // Walks the whole sleep ladder; the sleepless twin must sit in halt when the main instance first sleeps.
   task automatic t_sleep();
      logic seen;
      lpsmi_chipset_i.drive(P_SLP_RUN);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_RUN, pwr_q);
      lpsmi_chipset_i.drive(P_STOP);
      step(3);
      lpsmi_chipset_i.drive(P_SLEEP);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_SLEEP, pwr_q);
      chk_vec("clock enables", `LPSMI_CLKEN_OFF, clk_en_q);
      chk_vec("sleepless state", lpsmi_pkg::PWR_HALT, pwr_off);
      probe(1'b0, seen);
      chk_bit("snoop answer", 1'b0, seen);
      probe(1'b1, seen);
      chk_bit("interrupt answer", 1'b0, seen);
      lpsmi_chipset_i.drive(P_SLP_RUN);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_SLEEP, pwr_q);
      lpsmi_chipset_i.drive(P_DEEP);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_DEEP, pwr_q);
      lpsmi_chipset_i.drive(P_SLEEP);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_SLEEP, pwr_q);
      lpsmi_chipset_i.drive(P_GONE);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_DEEP, pwr_q);
      lpsmi_chipset_i.drive(P_SLEEP);
      step(3);
      lpsmi_chipset_i.drive(P_STOP);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_HALT, pwr_q);
      chk_vec("clock enables", `LPSMI_CLKEN_HALT, clk_en_q);
      lpsmi_chipset_i.drive(P_IDLE);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_RUN, pwr_q);
      $display("test sleep ladder done");
   endtask

   // Entry order is save, acknowledge, fetch, one cycle apart, after the synchroniser.
   // A halt taken inside the handler must use the extended variant and return to it.
   task automatic t_mgmt();
      lpsmi_chipset_i.drive(P_MGMT);
      step(3);
      chk_bit("state save", 1'b0, state_save_q);
      step(1);
      chk_bit("state save", 1'b1, state_save_q);
      chk_bit("handler mode", 1'b1, handler_mode_q);
      step(1);
      chk_vec("acknowledge", 3'h3, {1'b0, ack_q});
      chk_bit("fetch start", 1'b0, fetch_start_q);
      step(1);
      chk_bit("fetch start", 1'b1, fetch_start_q);
      lpsmi_chipset_i.drive(P_STOP);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_HALT_EXT, pwr_q);
      chk_vec("clock enables", `LPSMI_CLKEN_HALT, clk_en_q);
      chk_vec("acknowledge", 3'h2, {1'b0, ack_q});
      lpsmi_chipset_i.drive(P_SLEEP);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_SLEEP, pwr_q);
      lpsmi_chipset_i.drive(P_STOP);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_HALT_EXT, pwr_q);
      lpsmi_chipset_i.drive(P_IDLE);
      step(3);
      chk_vec("power state", lpsmi_pkg::PWR_RUN, pwr_q);
      chk_bit("handler mode", 1'b1, handler_mode_q);
      handler_exit = 1'b1;
      step(2);
      handler_exit = 1'b0;
      step(2);
      chk_bit("handler mode", 1'b0, handler_mode_q);
      lpsmi_chipset_i.drive(P_IDLE);
      $display("test management entry done");
   endtask

   task automatic t_reset();
      rstn = 1'b0;
      step(2);
      chk_bit("bus output enable", 1'b0, bus_out_en_q);
      chk_bit("cache invalidate", 1'b1, cache_inv_q);
      chk_vec("power state", lpsmi_pkg::PWR_RUN, pwr_q);
      lpsmi_chipset_i.drive(P_MGMT);
      step(4);
      rstn = 1'b1;
      step(1);
      chk_bit("high impedance", 1'b1, outputs_hiz_q);
      chk_bit("bus output enable", 1'b0, bus_out_en_q);
      lpsmi_chipset_i.drive(P_IDLE);
      rstn = 1'b0;
      step(4);
      rstn = 1'b1;
      step(1);
      chk_bit("high impedance", 1'b0, outputs_hiz_q);
      chk_bit("bus output enable", 1'b1, bus_out_en_q);
      $display("test reset effects done");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Reset for ten cycles, then run every scenario in turn.
   initial begin
      rstn = 1'b0;
      snoop_req = 1'b0;
      irq_req = 1'b0;
      handler_exit = 1'b0;
      step(10);
      rstn = 1'b1;
      step(1);
      chk_bit("cache invalidate", 1'b0, cache_inv_q);
      chk_bit("bus output enable", 1'b1, bus_out_en_q);
      t_halt();
      t_sleep();
      t_mgmt();
      t_reset();
      test_done();
   end

endmodule
